// ===== hdl/ufmc_pkg.sv
`default_nettype none
package ufmc_pkg;

  // ==========================================================
  // Register map, word index on the plain register port
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFF_MODE = 2'h0;
  localparam logic [1:0] OFF_RXDATA = 2'h1;
  localparam logic [1:0] OFF_STATUS = 2'h2;
  localparam logic [1:0] OFF_RATE = 2'h3;

  // ==========================================================
  // Mode register fields
  localparam int MODE_AUTO = 5;
  localparam int MODE_INV = 4;
  localparam int MODE_FAST = 3;
  localparam int MODE_PDS = 1;
  localparam int MODE_STOP = 0;
  localparam logic [5:0] MODE_RESET = 6'h00;

  // ==========================================================
  // Status register fields
  localparam int ST_AVAIL = 0;
  localparam int ST_OVF = 1;
  localparam int ST_FRM = 2;
  localparam int ST_PAR = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_FULL = 5;

  // ==========================================================
  // Rate generator and sampling
  localparam logic [15:0] RATE_RESET = 16'h0035;
  localparam logic [4:0] SPB_FAST = 5'h04;
  localparam logic [4:0] SPB_STD = 5'h10;
  localparam int AB_CNT_W = 24;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  // Falling edges of the sync character that span eight bit times
  localparam logic [2:0] SYNC_FALLS = 3'h5;

  typedef enum logic [1:0] {
    PDS_8N = 2'b00,
    PDS_8E = 2'b01,
    PDS_8O = 2'b10,
    PDS_9N = 2'b11
  } ufmc_pds_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP1 = 3'b100,
    RX_STOP2 = 3'b101
  } ufmc_rx_state_t;

  function automatic logic ufmc_parity_on(input logic [1:0] pds);
    return (pds == PDS_8E) || (pds == PDS_8O);
  endfunction

  function automatic logic [3:0] ufmc_last_bit(input logic [1:0] pds);
    return (pds == PDS_9N) ? 4'h8 : 4'h7;
  endfunction

endpackage
`default_nettype wire

// ===== hdl/ufmc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ufmc_fifo
  import ufmc_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_reg[rdPtr_reg];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wrPtr_reg] <= inData;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  a_fifo_bounds: assert property (@(posedge clk) disable iff (!rst_b)
    count_reg <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule // ufmc_fifo
`default_nettype wire

// ===== hdl/ufmc_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ufmc_mode_ctrl
  import ufmc_pkg::*;
#(
  parameter logic [15:0] RATE_INIT = RATE_RESET,
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic serialReceiveLine
);
  // ==========================================================
  // Declarations
  logic [5:0] mode_reg;
  logic [15:0] rateDiv_reg;
  logic [15:0] rateCnt_reg;
  logic rxMeta_reg;
  logic rxSync_reg;
  logic lvlPrev_reg;
  ufmc_rx_state_t rxState_reg;
  logic [4:0] tickCnt_reg;
  logic [3:0] bitCnt_reg;
  logic [8:0] shift_reg;
  logic parBad_reg;
  logic [2:0] abEdges_reg;
  logic [AB_CNT_W-1:0] abCnt_reg;
  logic rxHold_reg;
  logic ovf_reg;
  logic frm_reg;
  logic par_reg;
  logic [1:0] pds;
  logic fast;
  logic lvl;
  logic fallEdge;
  logic tick;
  logic [4:0] tickLast;
  logic [4:0] tickHalf;
  logic inFrame;
  logic bitStep;
  logic frameEnd;
  logic push;
  logic pop;
  logic abArmed;
  logic abDone;
  logic rxArmed;
  logic [15:0] abVal;
  logic [15:0] abDiv;
  logic fifoReady;
  logic fifoValid;
  logic [8:0] fifoData;
  logic [15:0] clrStat;
  logic [15:0] status;

  assign pds = mode_reg[MODE_PDS +: 2];
  assign fast = mode_reg[MODE_FAST];

  // ==========================================================
  // Register writes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_reg <= MODE_RESET;
    else if (regWr && regAddr == OFF_MODE)
      mode_reg <= regWdata[5:0];
    else if (abDone)
      mode_reg[MODE_AUTO] <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rateDiv_reg <= RATE_INIT;
    else if (regWr && regAddr == OFF_RATE)
      rateDiv_reg <= regWdata;
    else if (abDone)
      rateDiv_reg <= abDiv;
  end

  // ==========================================================
  // Rate generator: one tick every rateDiv+1 clocks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rateCnt_reg <= '0;
    else if (tick)
      rateCnt_reg <= rateDiv_reg;
    else
      rateCnt_reg <= rateCnt_reg - 1'b1;
  end

  assign tick = (rateCnt_reg == 16'h0000);
  assign tickLast = (fast ? SPB_FAST : SPB_STD) - 5'h01;
  assign tickHalf = ((fast ? SPB_FAST : SPB_STD) >> 1) - 5'h01;

  // ==========================================================
  // Line synchroniser and polarity
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxMeta_reg <= 1'b1;
      rxSync_reg <= 1'b1;
      lvlPrev_reg <= 1'b1;
    end
    else
    begin
      rxMeta_reg <= serialReceiveLine;
      rxSync_reg <= rxMeta_reg;
      lvlPrev_reg <= lvl;
    end
  end

  // Normalised so that the idle level is always 1
  assign lvl = rxSync_reg ^ mode_reg[MODE_INV];
  assign fallEdge = lvlPrev_reg && !lvl;

  // ==========================================================
  // Receive state machine
  assign inFrame = (rxState_reg != RX_IDLE) && (rxState_reg != RX_START);
  assign bitStep = inFrame && tick && (tickCnt_reg == tickLast);
  assign rxArmed = !mode_reg[MODE_AUTO] && !rxHold_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxState_reg <= RX_IDLE;
      tickCnt_reg <= '0;
      bitCnt_reg <= '0;
      shift_reg <= '0;
      parBad_reg <= 1'b0;
    end
    else
    begin
      if (tick && inFrame)
        tickCnt_reg <= bitStep ? 5'h00 : tickCnt_reg + 5'h01;
      unique case (rxState_reg)
        RX_IDLE:
          if (tick && !lvl && rxArmed)
          begin
            rxState_reg <= RX_START;
            tickCnt_reg <= '0;
          end
        RX_START:
          if (tick)
          begin
            if (tickCnt_reg == tickHalf)
            begin
              tickCnt_reg <= '0;
              bitCnt_reg <= '0;
              shift_reg <= '0;
              parBad_reg <= 1'b0;
              rxState_reg <= lvl ? RX_IDLE : RX_DATA;
            end
            else
              tickCnt_reg <= tickCnt_reg + 5'h01;
          end
        RX_DATA:
          if (bitStep)
          begin
            shift_reg[bitCnt_reg] <= lvl;
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == ufmc_last_bit(pds))
              rxState_reg <= ufmc_parity_on(pds) ? RX_PARITY : RX_STOP1;
          end
        RX_PARITY:
          if (bitStep)
          begin
            parBad_reg <= ((^shift_reg[7:0]) ^ lvl) != (pds == PDS_8O);
            rxState_reg <= RX_STOP1;
          end
        RX_STOP1:
          if (bitStep)
            rxState_reg <= (lvl && mode_reg[MODE_STOP]) ? RX_STOP2 : RX_IDLE;
        RX_STOP2:
          if (bitStep)
            rxState_reg <= RX_IDLE;
        default:
          rxState_reg <= RX_IDLE;
      endcase
    end
  end

  // A low stop bit ends the frame at once as a framing error
  assign frameEnd = bitStep && ((rxState_reg == RX_STOP1 &&
    !(lvl && mode_reg[MODE_STOP])) || rxState_reg == RX_STOP2);
  assign push = frameEnd && lvl;

  // ==========================================================
  // Rate detection on the sync character
  assign abArmed = mode_reg[MODE_AUTO] && (rxState_reg == RX_IDLE);
  assign abDone = abArmed && fallEdge &&
    (abEdges_reg == SYNC_FALLS - 3'h1);
  assign abVal = fast ? abCnt_reg[20:5] : abCnt_reg[22:7];
  assign abDiv = (abVal == 16'h0000) ? 16'h0000 : abVal - 16'h0001;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      abEdges_reg <= '0;
      abCnt_reg <= '0;
    end
    else if (!abArmed)
    begin
      abEdges_reg <= '0;
      abCnt_reg <= '0;
    end
    else
    begin
      if (abEdges_reg != 3'h0)
        abCnt_reg <= abCnt_reg + 1'b1;
      if (fallEdge)
        abEdges_reg <= abEdges_reg + 3'h1;
    end
  end

  // Keeps the tail of the sync character from starting a frame
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rxHold_reg <= 1'b0;
    else if (abDone)
      rxHold_reg <= 1'b1;
    else if (lvl)
      rxHold_reg <= 1'b0;
  end

  // ==========================================================
  // Receive buffer
  assign pop = regRd && (regAddr == OFF_RXDATA) && fifoValid;

  ufmc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(push),
    .inReady(fifoReady),
    .inData(shift_reg),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoData)
  );

  // ==========================================================
  // Sticky error flags, write one to clear, set wins
  assign clrStat = (regWr && regAddr == OFF_STATUS) ? regWdata : 16'h0000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovf_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
    end
    else
    begin
      ovf_reg <= (ovf_reg && !clrStat[ST_OVF]) || (push && !fifoReady);
      frm_reg <= (frm_reg && !clrStat[ST_FRM]) || (frameEnd && !lvl);
      par_reg <= (par_reg && !clrStat[ST_PAR]) || (push && parBad_reg);
    end
  end

  assign status = {10'h000, !fifoReady, rxState_reg == RX_IDLE,
    par_reg, frm_reg, ovf_reg, fifoValid};

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdata <= '0;
    else if (!regRd)
      regRdata <= '0;
    else
    begin
      unique case (regAddr)
        OFF_MODE: regRdata <= {10'h000, mode_reg};
        OFF_RXDATA: regRdata <= {7'h00, fifoValid ? fifoData : 9'h000};
        OFF_STATUS: regRdata <= status;
        OFF_RATE: regRdata <= rateDiv_reg;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_sync_not_data: assert property (mode_reg[MODE_AUTO] |-> !push)
    else $error("data stored while rate detection armed");
  a_auto_clears: assert property (abDone && !regWr |=>
    !mode_reg[MODE_AUTO] && rateDiv_reg == $past(abDiv))
    else $error("auto rate bit not cleared on completion");
  a_idle_level: assert property (rxState_reg == RX_IDLE && rxArmed &&
    tick && (rxSync_reg == mode_reg[MODE_INV]) |=> rxState_reg == RX_START)
    else $error("start level not detected");
  a_tick_count: assert property (bitStep |->
    tickCnt_reg == (fast ? 5'h03 : 5'h0F))
    else $error("wrong ticks per bit");
  a_parity_path: assert property (rxState_reg == RX_DATA && bitStep &&
    bitCnt_reg == 4'h7 && pds inside {PDS_8E, PDS_8O} |=>
    rxState_reg == RX_PARITY)
    else $error("parity bit skipped");
  a_nine_bits: assert property (push && pds != PDS_9N |->
    !shift_reg[8])
    else $error("ninth bit stored in eight bit mode");
  a_two_stops: assert property (rxState_reg == RX_STOP1 && bitStep &&
    lvl && mode_reg[MODE_STOP] |=> rxState_reg == RX_STOP2 ##0
    !push)
    else $error("second stop bit skipped");
  a_stop_check: assert property (frameEnd && !lvl |=>
    frm_reg && ($stable(u_fifo.count_reg) || $past(pop)))
    else $error("bad stop bit not flagged");
  a_read_timing: assert property (regRd && regAddr == OFF_MODE |=>
    regRdata == {10'h000, $past(mode_reg)})
    else $error("mode read data wrong");

  c_auto_done: cover property (abDone);
  c_parity_frame: cover property (push && ufmc_parity_on(pds));
  c_two_stop_frame: cover property (push && mode_reg[MODE_STOP]);
  c_overflow: cover property (push && !fifoReady);
endmodule // ufmc_mode_ctrl
`default_nettype wire

// ===== dv/ufmc_remote_tx.sv
`timescale 1ns/100ps
`default_nettype none
module ufmc_remote_tx
(
  input wire logic clk,
  input wire logic lineInv,
  output logic lineOut
);
  // ==========================================================
  // Line driver
  logic busy = 1'b0;
  logic bitVal = 1'b1;

  // Idle level follows the polarity setting of the receiver
  assign lineOut = (busy ? bitVal : 1'b1) ^ lineInv;

  // ==========================================================
  // Character sender
  task automatic put_bit(input logic v, input int cpb);
    bitVal <= v;
    busy <= 1'b1;
    repeat (cpb) @(posedge clk);
  endtask

  // Called right after a rising edge
  task automatic send_char(
    input logic [8:0] data,
    input int nData,
    input int parMode,
    input int nStop,
    input int cpb,
    input logic badPar,
    input logic badStop
  );
    logic par;
    par = (parMode == 2) ? ~^data[7:0] : ^data[7:0];
    put_bit(1'b0, cpb);
    for (int i = 0; i < nData; i++)
    begin
      put_bit(data[i], cpb);
    end
    if (parMode != 0)
    begin
      put_bit(par ^ badPar, cpb);
    end
    for (int i = 1; i <= nStop; i++)
    begin
      put_bit(~(badStop && i == nStop), cpb);
    end
    busy <= 1'b0;
  endtask
endmodule // ufmc_remote_tx
`default_nettype wire

// ===== dv/tb_ufmc_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ufmc_mode_ctrl
  import ufmc_pkg::*;
;
  // One tick per clock keeps frames short
  localparam logic [15:0] RATE_TB = 16'h0000;
  localparam int LIMIT = 20000;

  logic clk;
  logic rst_b;
  logic [ADDR_W-1:0] regAddr;
  logic [15:0] regWdata;
  logic regWr;
  logic regRd;
  logic [15:0] regRdata;
  logic lineInv;
  logic rxLine;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  typedef struct packed {
    logic [5:0] mode;
    logic [8:0] data;
    logic badPar;
    logic [15:0] expRx;
    logic [15:0] expSt;
  } ufmc_row_t;

  ufmc_row_t rows [10] = '{
    '{6'h00, 9'h0A5, 1'b0, 16'h00A5, 16'h0011},
    '{6'h02, 9'h0C3, 1'b0, 16'h00C3, 16'h0011},
    '{6'h04, 9'h081, 1'b0, 16'h0081, 16'h0011},
    '{6'h06, 9'h1A5, 1'b0, 16'h01A5, 16'h0011},
    '{6'h01, 9'h03C, 1'b0, 16'h003C, 16'h0011},
    '{6'h08, 9'h0F0, 1'b0, 16'h00F0, 16'h0011},
    '{6'h10, 9'h05A, 1'b0, 16'h005A, 16'h0011},
    '{6'h1B, 9'h0FE, 1'b0, 16'h00FE, 16'h0011},
    '{6'h02, 9'h011, 1'b1, 16'h0011, 16'h0019},
    '{6'h04, 9'h0FF, 1'b1, 16'h00FF, 16'h0019}
  };

  // ==========================================================
  // Design and remote sender
  ufmc_mode_ctrl #(.RATE_INIT(RATE_TB), .FIFO_DEPTH(8)) i_ufmc_mode_ctrl (
    .clk(clk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .serialReceiveLine(rxLine)
  );

  ufmc_remote_tx i_ufmc_remote_tx (
    .clk(clk),
    .lineInv(lineInv),
    .lineOut(rxLine)
  );

  // ==========================================================
  // Clock, timeout and verdict
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Register port and comparison tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Line polarity changes with the mode write; the synchroniser lag leaves lvl low for one cycle, so a false start appears
  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    if (a == OFF_MODE)
      lineInv <= d[MODE_INV];
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_check(input logic [1:0] a, input logic [15:0] m,
                          input logic [15:0] exp);
    logic [15:0] v;
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
    @(posedge clk);
    check(v & m, exp);
  endtask

  task automatic send(input logic [5:0] m, input logic [8:0] d,
                      input logic bp, input logic bs, input int cpb);
    int nData;
    int parMode;
    nData = (m[2:1] == 2'b11) ? 9 : 8;
    parMode = (m[2:1] == 2'b01) ? 1 : (m[2:1] == 2'b10) ? 2 : 0;
    i_ufmc_remote_tx.send_char(d, nData, parMode, m[0] + 1, cpb, bp, bs);
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    lineInv = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_check(OFF_MODE, 16'hFFFF, {10'h000, MODE_RESET});
    rd_check(OFF_RATE, 16'hFFFF, RATE_TB);
    reg_write(OFF_MODE, 16'hFFC0);
    rd_check(OFF_MODE, 16'hFFFF, 16'h0000);
    for (int r = 0; r < 10; r++)
    begin
      reg_write(OFF_MODE, {10'h000, rows[r].mode});
      send(rows[r].mode, rows[r].data, rows[r].badPar, 1'b0,
           rows[r].mode[MODE_FAST] ? 4 : 16);
      rd_check(OFF_STATUS, 16'h001F, rows[r].expSt);
      rd_check(OFF_RXDATA, 16'hFFFF, rows[r].expRx);
      reg_write(OFF_STATUS, 16'h000E);
    end
    // Second stop bit low must give a framing error
    reg_write(OFF_MODE, 16'h0001);
    send(6'h01, 9'h033, 1'b0, 1'b1, 16);
    repeat (40) @(posedge clk);
    rd_check(OFF_STATUS, 16'h000F, 16'h0004);
    reg_write(OFF_STATUS, 16'h000E);
    rd_check(OFF_STATUS, 16'h000F, 16'h0000);
    // Fill the buffer past full, then drain it
    reg_write(OFF_MODE, 16'h0008);
    for (int i = 0; i < 9; i++)
      send(6'h08, 9'(16 + i), 1'b0, 1'b0, 4);
    rd_check(OFF_STATUS, 16'h0023, 16'h0023);
    for (int i = 0; i < 8; i++)
      rd_check(OFF_RXDATA, 16'hFFFF, 16'(16 + i));
    rd_check(OFF_STATUS, 16'h0021, 16'h0000);
    reg_write(OFF_STATUS, 16'h000E);
    // Rate detection on a sync character at 66 clocks per bit
    reg_write(OFF_MODE, 16'h0020);
    rd_check(OFF_MODE, 16'h003F, 16'h0020);
    send(6'h00, 9'h055, 1'b0, 1'b0, 66);
    rd_check(OFF_MODE, 16'h003F, 16'h0000);
    rd_check(OFF_RATE, 16'hFFFF, 16'((8 * 66) / 128 - 1));
    rd_check(OFF_STATUS, 16'h0001, 16'h0000);
    send(6'h00, 9'h0C7, 1'b0, 1'b0, 64);
    rd_check(OFF_RXDATA, 16'hFFFF, 16'h00C7);
    // Reset in mid-run returns every register to its reset value
    reg_write(OFF_MODE, 16'h002B);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_check(OFF_MODE, 16'hFFFF, {10'h000, MODE_RESET});
    rd_check(OFF_RATE, 16'hFFFF, RATE_TB);
    rd_check(OFF_STATUS, 16'h003F, 16'h0010);
    finish_test();
  end
endmodule // tb_ufmc_mode_ctrl
`default_nettype wire
